// file: include/xcvr_ctl_pkg.sv
// constants shared by the transceiver pin-control block and its helpers
// assumes one 40 MHz clock and an AXI4-Lite master with 32-bit data
package xcvr_ctl_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned EN_W = 8;
  localparam int unsigned CH_N = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] LATCH_STATE_ADDR = 8'h00;
  localparam logic [7:0] LINK_STATE_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_ADDR = 8'h0C;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h10;

  // field positions inside the readable words
  localparam int unsigned DRV_LSB = 0;
  localparam int unsigned BIST_LSB = 8;
  localparam int unsigned RXPWR_LSB = 16;
  localparam int unsigned FAULT_LSB = 0;
  localparam int unsigned CODE_LSB = 4;
  localparam int unsigned SLAVE_BIT = 6;
  localparam int unsigned LEAD_LSB = 8;

  // interrupt event bits
  localparam int unsigned IRQ_N = 4;
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_SYNC = 1;
  localparam int unsigned EV_INSERT = 2;
  localparam int unsigned EV_DELETE = 3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] DRV_RESET = 8'hFF;   // every serial driver on
  localparam logic [7:0] BIST_RESET = 8'hFF;  // self-test off everywhere
  localparam logic [7:0] RXPWR_RESET = 8'hFF; // every receive channel on
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;

  // ****************************************************************
  // bonding status codes
  // ****************************************************************
  localparam logic [1:0] BOND_WORD_SYNC = 2'h0;
  localparam logic [1:0] BOND_INSERT = 2'h1;
  localparam logic [1:0] BOND_DELETE = 2'h2;
  localparam logic [1:0] BOND_NORMAL = 2'h3;

  // ****************************************************************
  // axi response codes
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : xcvr_ctl_pkg

// file: logic/pin_sync.sv
// two-flop synchroniser for asynchronous pins
// assumes the destination clock is mclk_in; the first flop feeds only the second
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // two stages; only sync_reg is visible outside
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : pin_sync
`default_nettype wire

// file: logic/enable_latch.sv
// one enable latch: transparent while its strobe is high, holds when low
// assumes strobe and data have already been synchronised to mclk_in
`timescale 1ns/100ps
`default_nettype none
module enable_latch #(
  parameter logic [7:0] RESET_VAL = 8'hFF
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // strobe and shared data
  input wire logic strobe_in,
  input wire logic [7:0] data_in,
  // latched value
  output logic [7:0] latch_out
);

  logic [7:0] latch_reg;

  // modelled as a flop so timing stays in one domain; reset forces the
  // safe all-ones value whatever the strobe was doing
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      latch_reg <= RESET_VAL;
    end else if (strobe_in) begin
      latch_reg <= data_in;
    end
  end

  assign latch_out = latch_reg;

endmodule : enable_latch
`default_nettype wire

// file: logic/xcvr_pin_ctl.sv
// transceiver pin control: enable latches, link fault pins, bonding status
// bus and an AXI4-Lite register window with interrupt
// assumes mclk_in is the receive output clock; pins are asynchronous
//
// Summary of operation
// - driver latch follows bus while strobe high
// - self-test latch follows bus while strobe high
// - receive-power latch follows bus while strobe high
// - reset leaves every receive channel enabled
// - link fault low on any of four conditions
// - bond bus used only between bonded devices
// - bond bus timed with receive output data
// - master drives lead channel buffer status
// - code 00 means word sync received
// - code 01 means insert one K28.5
// - code 10 deletes framing, 11 normal
// - slave leaves bond bus undriven, reads it
// - driver bit high enables, low powers down
// - self-test bit low selects pattern mode
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module xcvr_pin_ctl (
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // enable pins
  input wire logic [7:0] shared_enable_bus_in,
  input wire logic driver_latch_strobe_in,
  input wire logic selftest_latch_strobe_in,
  input wire logic rx_power_latch_strobe_in,
  // latched enables to the analog and test logic
  output logic [7:0] driver_enable_out,
  output logic [7:0] selftest_enable_n_out,
  output logic [7:0] rx_power_enable_out,
  // receive quality conditions, one bit per channel a..d
  input wire logic [3:0] freq_out_of_range_in,
  input wire logic [3:0] amplitude_low_in,
  input wire logic [3:0] density_low_in,
  // link fault pins
  output logic link_fault_n_a_out,
  output logic link_fault_n_b_out,
  output logic link_fault_n_c_out,
  output logic link_fault_n_d_out,
  // elastic buffer events, one bit per channel a..d
  input wire logic [3:0] eb_word_sync_in,
  input wire logic [3:0] eb_insert_in,
  input wire logic [3:0] eb_delete_in,
  // bonding configuration pins
  input wire logic master_select_n_in,
  input wire logic lead_channel_select_b_in,
  input wire logic lead_channel_select_d_in,
  // open-drain bonding status bus
  input wire logic [1:0] bond_status_bus_in,
  output logic [1:0] bond_status_bus_out,
  output logic [1:0] bond_status_bus_oe_n_out,
  output logic [1:0] bond_code_out,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq_out
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [7:0] bus_sync;
  logic [2:0] strobe_sync;
  logic [2:0] cfg_sync;
  logic [1:0] bond_in_sync;

  pin_sync #(.WIDTH(8), .RESET_VAL(8'hFF)) u_bus_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .async_in(shared_enable_bus_in),
    .sync_out(bus_sync)
  );

  // strobes reset low so no latch opens while reset is being released
  pin_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_strobe_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .async_in({rx_power_latch_strobe_in, selftest_latch_strobe_in,
               driver_latch_strobe_in}),
    .sync_out(strobe_sync)
  );

  // reset as slave so the bus is never driven before the straps settle
  pin_sync #(.WIDTH(3), .RESET_VAL(3'h1)) u_cfg_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .async_in({lead_channel_select_d_in, lead_channel_select_b_in, master_select_n_in}),
    .sync_out(cfg_sync)
  );

  pin_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_bond_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .async_in(bond_status_bus_in),
    .sync_out(bond_in_sync)
  );

  logic slave_mode;
  logic [1:0] lead_ch;
  assign slave_mode = cfg_sync[0];
  assign lead_ch = cfg_sync[2:1];

  // ****************************************************************
  // enable latches
  // ****************************************************************
  // driver: high bit enables the differential driver, low powers it down
  enable_latch #(.RESET_VAL(xcvr_ctl_pkg::DRV_RESET)) u_drv_latch (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .strobe_in(strobe_sync[0]),
    .data_in(bus_sync),
    .latch_out(driver_enable_out)
  );

  // self-test: low bit puts the channel in pattern generate or compare
  enable_latch #(.RESET_VAL(xcvr_ctl_pkg::BIST_RESET)) u_bist_latch (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .strobe_in(strobe_sync[1]),
    .data_in(bus_sync),
    .latch_out(selftest_enable_n_out)
  );

  enable_latch #(.RESET_VAL(xcvr_ctl_pkg::RXPWR_RESET)) u_rx_latch (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .strobe_in(strobe_sync[2]),
    .data_in(bus_sync),
    .latch_out(rx_power_enable_out)
  );

  // ****************************************************************
  // link fault outputs
  // ****************************************************************
  // channel x is powered only while both of its enable bits are high
  function automatic logic [3:0] rx_disabled(input logic [7:0] en);
    logic [3:0] dis;
    dis = '0;
    for (int i = 0; i < 4; i++) begin
      dis[i] = !(en[2*i] && en[2*i+1]);
    end
    return dis;
  endfunction : rx_disabled

  logic [3:0] fault_cond;
  logic [3:0] fault_n_reg;
  assign fault_cond = freq_out_of_range_in | amplitude_low_in | density_low_in
                    | rx_disabled(rx_power_enable_out);

  // registered so the pins move with the receive output clock
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_n_reg <= 4'hF;
    end else begin
      fault_n_reg <= ~fault_cond;
    end
  end

  assign link_fault_n_a_out = fault_n_reg[0];
  assign link_fault_n_b_out = fault_n_reg[1];
  assign link_fault_n_c_out = fault_n_reg[2];
  assign link_fault_n_d_out = fault_n_reg[3];

  // ****************************************************************
  // bonding status bus
  // ****************************************************************
  // word sync outranks insert, insert outranks delete
  function automatic logic [1:0] eb_code(input logic sync, input logic ins, input logic del);
    logic [1:0] c;
    c = xcvr_ctl_pkg::BOND_NORMAL;
    if (sync) begin
      c = xcvr_ctl_pkg::BOND_WORD_SYNC;
    end else if (ins) begin
      c = xcvr_ctl_pkg::BOND_INSERT;
    end else if (del) begin
      c = xcvr_ctl_pkg::BOND_DELETE;
    end
    return c;
  endfunction : eb_code

  logic [1:0] code_reg;
  logic [1:0] master_code;
  assign master_code = eb_code(eb_word_sync_in[lead_ch], eb_insert_in[lead_ch],
                               eb_delete_in[lead_ch]);

  // one register stage, same edge as the parallel receive data
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      code_reg <= xcvr_ctl_pkg::BOND_NORMAL;
    end else if (slave_mode) begin
      code_reg <= bond_in_sync;
    end else begin
      code_reg <= master_code;
    end
  end

  // open drain: only a zero is ever driven, a slave drives nothing; the
  // bus only matters when devices are bonded, otherwise it floats high
  assign bond_status_bus_out = 2'h0;
  assign bond_status_bus_oe_n_out = slave_mode ? 2'h3 : code_reg;
  assign bond_code_out = code_reg;

  // ****************************************************************
  // interrupt events and registers
  // ****************************************************************
  logic [3:0] irq_status_reg;
  logic [3:0] irq_enable_reg;
  logic [3:0] irq_clear;
  logic [3:0] irq_event;
  logic [3:0] fault_n_prev_reg;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_n_prev_reg <= 4'hF;
    end else begin
      fault_n_prev_reg <= fault_n_reg;
    end
  end

  assign irq_event[xcvr_ctl_pkg::EV_FAULT] = |(fault_n_prev_reg & ~fault_n_reg);
  assign irq_event[xcvr_ctl_pkg::EV_SYNC] = (code_reg == xcvr_ctl_pkg::BOND_WORD_SYNC);
  assign irq_event[xcvr_ctl_pkg::EV_INSERT] = (code_reg == xcvr_ctl_pkg::BOND_INSERT);
  assign irq_event[xcvr_ctl_pkg::EV_DELETE] = (code_reg == xcvr_ctl_pkg::BOND_DELETE);

  // a new event in the clearing cycle wins, so nothing is lost
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status_reg <= 4'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
    end
  end

  assign irq_out = |(irq_status_reg & irq_enable_reg);

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_go;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == xcvr_ctl_pkg::LATCH_STATE_ADDR) || (a == xcvr_ctl_pkg::LINK_STATE_ADDR)
        || (a == xcvr_ctl_pkg::IRQ_STATUS_ADDR) || (a == xcvr_ctl_pkg::IRQ_CLEAR_ADDR)
        || (a == xcvr_ctl_pkg::IRQ_ENABLE_ADDR);
  endfunction : is_mapped

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign wr_go = aw_have_reg && w_have_reg;

  // address and data are taken in either order and held until both exist
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (wr_go) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= xcvr_ctl_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(awaddr_reg) ? xcvr_ctl_pkg::RESP_OKAY
                                         : xcvr_ctl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // clear is a one-cycle pulse; only the low byte lane carries bits
  assign irq_clear = (wr_go && awaddr_reg == xcvr_ctl_pkg::IRQ_CLEAR_ADDR && wstrb_reg[0])
                   ? wdata_reg[3:0] : 4'h0;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_enable_reg <= xcvr_ctl_pkg::IRQ_EN_RESET;
    end else if (wr_go && awaddr_reg == xcvr_ctl_pkg::IRQ_ENABLE_ADDR && wstrb_reg[0]) begin
      irq_enable_reg <= wdata_reg[3:0];
    end
  end

  // read data are built from live state at the address handshake
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'h0})
      xcvr_ctl_pkg::LATCH_STATE_ADDR: begin
        rd_word[xcvr_ctl_pkg::DRV_LSB +: 8] = driver_enable_out;
        rd_word[xcvr_ctl_pkg::BIST_LSB +: 8] = selftest_enable_n_out;
        rd_word[xcvr_ctl_pkg::RXPWR_LSB +: 8] = rx_power_enable_out;
      end
      xcvr_ctl_pkg::LINK_STATE_ADDR: begin
        rd_word[xcvr_ctl_pkg::FAULT_LSB +: 4] = fault_n_reg;
        rd_word[xcvr_ctl_pkg::CODE_LSB +: 2] = code_reg;
        rd_word[xcvr_ctl_pkg::SLAVE_BIT] = slave_mode;
        rd_word[xcvr_ctl_pkg::LEAD_LSB +: 2] = lead_ch;
      end
      xcvr_ctl_pkg::IRQ_STATUS_ADDR: rd_word[3:0] = irq_status_reg;
      xcvr_ctl_pkg::IRQ_ENABLE_ADDR: rd_word[3:0] = irq_enable_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= xcvr_ctl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= is_mapped({s_axi_araddr[7:2], 2'h0}) ? xcvr_ctl_pkg::RESP_OKAY
                                                       : xcvr_ctl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  a_drv_follow: assert property (strobe_sync[0] |=> driver_enable_out == $past(bus_sync))
    else $error("driver latch did not follow bus");
  a_drv_hold: assert property (!strobe_sync[0] |=> $stable(driver_enable_out))
    else $error("driver latch changed while closed");
  a_bist_follow: assert property (strobe_sync[1] |=> selftest_enable_n_out == $past(bus_sync))
    else $error("self-test latch did not follow bus");
  a_rx_latch: assert property (!strobe_sync[2] ##1 !strobe_sync[2] |-> $stable(rx_power_enable_out))
    else $error("receive latch changed while closed");
  a_fault_cause: assert property (##1 1'b1 |-> fault_n_reg == ~$past(fault_cond))
    else $error("link fault does not match its conditions");
  a_fault_rxoff: assert property (rx_power_enable_out[1:0] != 2'h3 |=> !link_fault_n_a_out)
    else $error("disabled channel a shows no fault");
  a_code_sync: assert property (!slave_mode && eb_word_sync_in[lead_ch]
                                |=> code_reg == xcvr_ctl_pkg::BOND_WORD_SYNC)
    else $error("word sync not reported");
  a_code_insert: assert property (!slave_mode && !eb_word_sync_in[lead_ch] && eb_insert_in[lead_ch]
                                  |=> code_reg == xcvr_ctl_pkg::BOND_INSERT)
    else $error("insert not reported");
  a_code_idle: assert property (!slave_mode && !eb_word_sync_in[lead_ch] && !eb_insert_in[lead_ch]
                                && !eb_delete_in[lead_ch] |=> code_reg == xcvr_ctl_pkg::BOND_NORMAL)
    else $error("normal code not reported");
  a_slave_float: assert property (slave_mode |-> bond_status_bus_oe_n_out == 2'h3)
    else $error("slave drives the bonding bus");
  a_master_drive: assert property (!slave_mode |-> bond_status_bus_oe_n_out == code_reg)
    else $error("master bus does not show its code");

endmodule : xcvr_pin_ctl
`default_nettype wire

// file: verification/bond_peer.sv
// bonded peer on the open-drain bonding status wire, with its pull-up
// assumes both parties only ever pull low; a released line floats high
`timescale 1ns/100ps
`default_nettype none
module bond_peer (
  // pull-down enables, low pulls the line
  input wire logic [1:0] dev_oe_n_in,
  input wire logic [1:0] peer_oe_n_in,
  // resolved line level
  output logic [1:0] wire_out
);
  // wired and: the pull-up shows only where nobody pulls low
  assign wire_out = dev_oe_n_in & peer_oe_n_in;
endmodule : bond_peer
`default_nettype wire

// file: verification/xcvr_pin_ctl_tb.sv
// self-checking bench for the transceiver pin control block
// assumes the bond_peer model; register reads are scored from a queue
`timescale 1ns/100ps
`default_nettype none
module xcvr_pin_ctl_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic mclk_in = 1'b0;
  logic nrst_in, master_select_n_in, lead_channel_select_b_in, lead_channel_select_d_in, irq_out;
  logic [7:0] shared_enable_bus_in, driver_enable_out, selftest_enable_n_out;
  logic [7:0] rx_power_enable_out, s_axi_awaddr, s_axi_araddr;
  logic [3:0] freq_out_of_range_in, amplitude_low_in, density_low_in, s_axi_wstrb, f;
  logic [3:0] eb_word_sync_in, eb_insert_in, eb_delete_in, m;
  logic link_fault_n_a_out, link_fault_n_b_out, link_fault_n_c_out, link_fault_n_d_out;
  logic [1:0] bond_status_bus_in, bond_status_bus_out, bond_status_bus_oe_n_out;
  logic [1:0] bond_code_out, s_axi_bresp, s_axi_rresp, peer_oe_n;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] stb;
  logic [23:0] lat;
  logic [15:0] seed;
  logic [33:0] notes[$];
  logic [33:0] note;
  int num_errors = 0;
  int check_count = 0;
  wire driver_latch_strobe_in = stb[0];
  wire selftest_latch_strobe_in = stb[1];
  wire rx_power_latch_strobe_in = stb[2];
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

  xcvr_pin_ctl DUT (.*);
  bond_peer PEER (.dev_oe_n_in(bond_status_bus_oe_n_out), .peer_oe_n_in(peer_oe_n),
    .wire_out(bond_status_bus_in));

  always #12.5 mclk_in = ~mclk_in;

  // scoreboard: each bus answer is matched against the oldest note
  always @(posedge mclk_in) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      note = notes.pop_front();
      `CHK(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, note)
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick

  // each half stays up until its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    notes.push_back({r, 32'h0});
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge mclk_in); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    notes.push_back(e);
    @(posedge mclk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk_in); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk_in); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    tally_and_finish();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {nrst_in, stb, shared_enable_bus_in, master_select_n_in, peer_oe_n} = 15'h0003;
    {lead_channel_select_b_in, lead_channel_select_d_in, s_axi_wstrb} = 6'h0F;
    {freq_out_of_range_in, amplitude_low_in, density_low_in} = 12'h000;
    {eb_word_sync_in, eb_insert_in, eb_delete_in} = 12'h000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    lat = 24'hFFFFFF;
    seed = 16'h187B;
    tick(3);
    nrst_in <= 1'b1;
    tick(4);
    rd(8'h00, {10'h0, lat});
    rd(8'h10, 34'h0);
    rd(8'h14, {2'h2, 32'h0});
    wr(8'h20, 32'hF, 2'h2);
    $display("reset and map test done");
    // open, follow a second value, close, then disturb the bus
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      shared_enable_bus_in <= ~seed[7:0];
      stb[k] <= 1'b1;
      tick(5);
      shared_enable_bus_in <= seed[7:0];
      tick(5);
      stb[k] <= 1'b0;
      tick(5);
      shared_enable_bus_in <= seed[15:8];
      lat[8*k +: 8] = seed[7:0];
      tick(5);
      rd(8'h00, {10'h0, lat});
      `CHK({rx_power_enable_out, selftest_enable_n_out, driver_enable_out}, lat)
    end
    $display("latch test done");
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      if (i == 8) seed = 16'h0;
      {freq_out_of_range_in, amplitude_low_in, density_low_in} <= seed[11:0];
      for (int c = 0; c < 4; c++) f[c] = ~(seed[c] | seed[c+4] | seed[c+8] | ~&lat[16+2*c +: 2]);
      tick(3);
      rd(8'h04, {28'h0, 2'h3, f});
      `CHK({link_fault_n_d_out, link_fault_n_c_out, link_fault_n_b_out, link_fault_n_a_out}, f)
    end
    $display("link fault test done");
    // events on every other channel must not leak into the code
    for (int l = 0; l < 4; l++) for (int k = 0; k < 4; k++) begin
      m = 4'h1 << l;
      {lead_channel_select_d_in, lead_channel_select_b_in} <= l[1:0];
      eb_word_sync_in <= (k == 0 ? m : 4'h0) | ~m;
      eb_insert_in <= (k < 2 ? m : 4'h0) | ~m;
      eb_delete_in <= (k < 3 ? m : 4'h0) | ~m;
      tick(5);
      `CHK({bond_status_bus_out, bond_status_bus_oe_n_out, bond_code_out}, {2'h0, k[1:0], k[1:0]})
      rd(8'h04, {24'h0, l[1:0], 2'h0, k[1:0], f});
    end
    $display("bond master test done");
    {eb_word_sync_in, eb_insert_in, eb_delete_in} <= 12'h000;
    wr(8'h0C, 32'hF, 2'h0);
    rd(8'h08, 34'h0);
    eb_word_sync_in <= m;
    tick(3);
    eb_word_sync_in <= 4'h0;
    tick(3);
    rd(8'h08, 34'h2);
    `CHK(irq_out, 1'b0)
    wr(8'h10, 32'h2, 2'h0);
    rd(8'h10, 34'h2);
    `CHK(irq_out, 1'b1)
    wr(8'h0C, 32'h2, 2'h0);
    rd(8'h08, 34'h0);
    `CHK(irq_out, 1'b0)
    $display("interrupt test done");
    master_select_n_in <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      peer_oe_n <= k[1:0];
      tick(6);
      `CHK(bond_status_bus_oe_n_out, 2'h3)
      rd(8'h04, {24'h0, 2'h3, 2'h1, k[1:0], f});
    end
    $display("bond slave test done");
    // second reset while every strobe is closed and the receive latch is not all ones
    nrst_in <= 1'b0;
    tick(2);
    nrst_in <= 1'b1;
    tick(4);
    rd(8'h00, {10'h0, 24'hFFFFFF});
    `CHK(rx_power_enable_out, 8'hFF)
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule : xcvr_pin_ctl_tb
`default_nettype wire
